// ===== design/csr_top.sv
// Read-only clock synchronization readouts with limit checking and an
// interrupt status bank.
// Assumes the sync algorithm hands over each correction term as a one-cycle
// strobe, and that idle time and cycle number come from the protocol timer.
module csr_top
  import csr_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Host register port
  input wire csr_bus_req_t BUS_REQ,
  output logic [DATA_W-1:0] RDATA,
  // Protocol timing
  input wire logic NIT_ACTIVE,
  input wire logic [CYC_W-1:0] CYCLE_NUM,
  input wire logic [SLOT_W-1:0] SLOT_NUM_B,
  // Clock sync algorithm results
  input wire csr_corr_in_t RATE_IN,
  input wire csr_corr_in_t OFFSET_IN,
  // Interrupt and flag
  output logic IRQ,
  output logic CORR_LIMIT_FLAG
);

  // Magnitude needs one extra bit so that the most negative value fits
  function automatic logic [CORR_W:0] corr_mag(input logic [CORR_W-1:0] v);
    logic [CORR_W:0] m;
    m = {1'b0, v};
    if (v[CORR_W-1]) begin
      m = 17'h10000 - {1'b0, v};
    end
    return m;
  endfunction : corr_mag

  function automatic logic exceeds(input logic [CORR_W-1:0] v,
                                   input logic [DATA_W-1:0] limit);
    return corr_mag(v) > {1'b0, limit};
  endfunction : exceeds

  // Keeps the raw algorithm width separate from the field width
  function automatic logic [DATA_W-1:0] sext(input logic [CORR_W-1:0] v);
    return DATA_W'(signed'(v));
  endfunction : sext

  function automatic logic is_ro(input logic [ADDR_W-1:0] a);
    logic r;
    r = 1'b0;
    if (a == OFS_SLOT_B) begin
      r = 1'b1;
    end else if (a == OFS_RATE) begin
      r = 1'b1;
    end else if (a == OFS_OFFSET) begin
      r = 1'b1;
    end else if (a == OFS_LIMIT_SRC) begin
      r = 1'b1;
    end
    return r;
  endfunction : is_ro

  csr_state_t st_ff;
  csr_state_t nxt_st;

  logic rate_evt;
  logic rate_take;
  logic rate_miss;
  logic rate_lim;
  logic offs_evt;
  logic offs_take;
  logic offs_miss;
  logic offs_lim;
  logic ro_write;
  logic [STAT_W-1:0] evt;
  logic [STAT_W-1:0] clr;
  logic [DATA_W-1:0] rd_val;

  always_comb begin
    nxt_st = st_ff;
    rd_val = 16'h0000;
    clr = 6'h00;
    evt = 6'h00;

    // Slot number follows the channel B counter every cycle
    nxt_st.slot = SLOT_NUM_B; // [R1]

    // Rate term: only the odd cycle idle time may refresh the readout
    rate_evt = RATE_IN.vld & RATE_IN.enough;
    rate_take = rate_evt & NIT_ACTIVE & CYCLE_NUM[0]; // [R3]
    rate_miss = RATE_IN.vld & ~RATE_IN.enough;
    rate_lim = rate_evt & exceeds(RATE_IN.value, st_ff.max_rate); // [R5]
    if (rate_take) begin
      // Raw value, no clamping and no external term added
      nxt_st.rate = sext(RATE_IN.value); // [R2] [R4]
    end
    // A strobe without enough sync frames leaves the readout alone [R6]

    // Offset term: refreshed in every idle time
    offs_evt = OFFSET_IN.vld & OFFSET_IN.enough;
    offs_take = offs_evt & NIT_ACTIVE; // [R8]
    offs_miss = OFFSET_IN.vld & ~OFFSET_IN.enough;
    offs_lim = offs_evt & exceeds(OFFSET_IN.value, st_ff.max_offs); // [R10]
    if (offs_take) begin
      nxt_st.offs = sext(OFFSET_IN.value); // [R7] [R9]
    end
    // Too few sync frames: previous offset kept [R11]

    // Remember which term hit its limit last; both may hit together
    if (rate_lim | offs_lim) begin
      nxt_st.limit_src = {offs_lim, rate_lim};
    end

    // Host writes
    ro_write = BUS_REQ.wr & is_ro(BUS_REQ.addr); // [R12]
    if (BUS_REQ.wr) begin
      if (BUS_REQ.addr == OFS_MAX_RATE) begin
        nxt_st.max_rate = BUS_REQ.wdata;
      end else if (BUS_REQ.addr == OFS_MAX_OFFSET) begin
        nxt_st.max_offs = BUS_REQ.wdata;
      end else if (BUS_REQ.addr == OFS_IRQ_STAT) begin
        clr = BUS_REQ.wdata[STAT_W-1:0];
      end else if (BUS_REQ.addr == OFS_IRQ_MASK) begin
        nxt_st.mask = BUS_REQ.wdata[STAT_W-1:0];
      end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    evt[BIT_LIMIT] = rate_lim | offs_lim; // [R5] [R10]
    evt[BIT_RATE_UPD] = rate_take;
    evt[BIT_OFFS_UPD] = offs_take;
    evt[BIT_RATE_MISS] = rate_miss;
    evt[BIT_OFFS_MISS] = offs_miss;
    evt[BIT_RO_WRITE] = ro_write;
    nxt_st.status = (st_ff.status & ~clr) | evt;

    // Host reads: data valid in the following cycle only
    if (BUS_REQ.rd) begin
      if (BUS_REQ.addr == OFS_SLOT_B) begin
        rd_val = {5'h00, st_ff.slot}; // [R1]
      end else if (BUS_REQ.addr == OFS_RATE) begin
        rd_val = st_ff.rate;
      end else if (BUS_REQ.addr == OFS_OFFSET) begin
        rd_val = st_ff.offs;
      end else if (BUS_REQ.addr == OFS_MAX_RATE) begin
        rd_val = st_ff.max_rate;
      end else if (BUS_REQ.addr == OFS_MAX_OFFSET) begin
        rd_val = st_ff.max_offs;
      end else if (BUS_REQ.addr == OFS_IRQ_STAT) begin
        rd_val = {10'h000, st_ff.status};
      end else if (BUS_REQ.addr == OFS_IRQ_MASK) begin
        rd_val = {10'h000, st_ff.mask};
      end else if (BUS_REQ.addr == OFS_LIMIT_SRC) begin
        rd_val = {14'h0000, st_ff.limit_src};
      end else begin
        rd_val = 16'h0000;
      end
    end
    nxt_st.rdata = rd_val;

    // Level interrupt tracks the status it is registered beside
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_ff <= CSR_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RDATA = st_ff.rdata;
  assign IRQ = st_ff.irq;
  assign CORR_LIMIT_FLAG = st_ff.status[BIT_LIMIT];

endmodule : csr_top

// ===== design/csr_pkg.sv
// Constants, carrier types and reset values of the clock sync readout bank.
// Assumes one protocol clock domain and a host on a plain strobe port.
// Contract
// [R1] Show the channel B slot number in progress in an 11-bit field.
// [R2] Show the rate correction as 16-bit two's complement, sign extended.
// [R3] Refresh the rate readout only in the idle time of odd cycles.
// [R4] Rate readout holds the raw result, before limiting and external terms.
// [R5] Rate magnitude above its configured maximum sets the limit flag.
// [R6] Without enough sync frames the rate readout keeps its old value.
// [R7] Show the offset correction as 16-bit two's complement, sign extended.
// [R8] Refresh the offset readout in the idle time of every cycle.
// [R9] Offset readout holds the raw result, before limiting and external terms.
// [R10] Offset magnitude above its configured maximum sets the limit flag.
// [R11] Without enough sync frames the offset readout keeps its old value.
// [R12] The three readouts are read-only; host writes leave them untouched.
package csr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SLOT_W = 11;
  localparam int CORR_W = 16;
  localparam int CYC_W = 6;
  localparam int STAT_W = 6;

  // Register offsets
  localparam logic [7:0] OFS_SLOT_B = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_MAX_RATE = 8'h0c;
  localparam logic [7:0] OFS_MAX_OFFSET = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_LIMIT_SRC = 8'h1c;

  // Status and mask bit positions
  localparam int BIT_LIMIT = 0;
  localparam int BIT_RATE_UPD = 1;
  localparam int BIT_OFFS_UPD = 2;
  localparam int BIT_RATE_MISS = 3;
  localparam int BIT_OFFS_MISS = 4;
  localparam int BIT_RO_WRITE = 5;

  // Reset values
  localparam logic [15:0] RST_CORR = 16'h0000;
  localparam logic [15:0] RST_MAX = 16'h0000;
  localparam logic [5:0] RST_MASK = 6'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } csr_bus_req_t;

  typedef struct packed {
    logic vld;
    logic enough;
    logic [CORR_W-1:0] value;
  } csr_corr_in_t;

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] rate;
    logic [DATA_W-1:0] offs;
    logic [DATA_W-1:0] max_rate;
    logic [DATA_W-1:0] max_offs;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [1:0] limit_src;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } csr_state_t;

  localparam csr_state_t CSR_ST_RST = '{
    slot: 11'h000,
    rate: RST_CORR,
    offs: RST_CORR,
    max_rate: RST_MAX,
    max_offs: RST_MAX,
    status: 6'h00,
    mask: RST_MASK,
    limit_src: 2'h0,
    rdata: 16'h0000,
    irq: 1'b0
  };

endpackage : csr_pkg

// ===== sim/csr_top_sva.sv
// Checker for the clock sync readout bank, bound to csr_top.
// Assumes one protocol clock and a synchronous active-high reset.
module csr_top_chk
  import csr_pkg::*;
(
  // Clock and reset
  input logic CLK,
  input logic SYS_RST,
  // Host port
  input csr_bus_req_t BUS_REQ,
  input logic [DATA_W-1:0] RDATA,
  // Protocol side
  input logic NIT_ACTIVE,
  input logic [CYC_W-1:0] CYCLE_NUM,
  input logic [SLOT_W-1:0] SLOT_NUM_B,
  input csr_corr_in_t RATE_IN,
  input csr_corr_in_t OFFSET_IN,
  input logic IRQ,
  input logic CORR_LIMIT_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Shadows follow only accepted terms, so a stray update shows on read
  logic [15:0] rate_ff, offs_ff;
  logic [10:0] slot_ff;
  wire ev = RATE_IN.vld && RATE_IN.enough || OFFSET_IN.vld && OFFSET_IN.enough;
  wire rd = BUS_REQ.rd;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rate_ff <= RST_CORR;
      offs_ff <= RST_CORR;
      slot_ff <= 11'h000;
    end else begin
      slot_ff <= SLOT_NUM_B;
      if (RATE_IN.vld && RATE_IN.enough && NIT_ACTIVE && CYCLE_NUM[0]) begin
        rate_ff <= RATE_IN.value;
      end
      if (OFFSET_IN.vld && OFFSET_IN.enough && NIT_ACTIVE) begin
        offs_ff <= OFFSET_IN.value;
      end
    end
  end
  a_slot_read: assert property (rd && BUS_REQ.addr == OFS_SLOT_B |=>
    RDATA == {5'h00, $past(slot_ff)}) else $error("slot readout wrong");
  a_rate_read: assert property (rd && BUS_REQ.addr == OFS_RATE |=>
    RDATA == $past(rate_ff)) else $error("rate readout wrong");
  a_offs_read: assert property (rd && BUS_REQ.addr == OFS_OFFSET |=>
    RDATA == $past(offs_ff)) else $error("offset readout wrong");
  a_rdata_idle: assert property (!rd |=> RDATA == 16'h0000)
    else $error("read data outside read");
  a_flag_rise: assert property ($rose(CORR_LIMIT_FLAG) |-> $past(ev))
    else $error("limit flag without term");
  a_flag_fall: assert property ($fell(CORR_LIMIT_FLAG) |-> $past(BUS_REQ.wr
    && BUS_REQ.addr == OFS_IRQ_STAT && BUS_REQ.wdata[BIT_LIMIT]))
    else $error("limit flag lost");
  // Strobes without enough frames set status bits too, so any strobe counts
  a_irq_rise: assert property ($rose(IRQ) |->
    $past(RATE_IN.vld || OFFSET_IN.vld || BUS_REQ.wr))
    else $error("irq without cause");
  a_irq_fall: assert property ($fell(IRQ) |-> $past(BUS_REQ.wr))
    else $error("irq dropped without write");
endmodule : csr_top_chk

bind csr_top csr_top_chk i_chk(.CLK(CLK), .SYS_RST(SYS_RST),
  .BUS_REQ(BUS_REQ), .RDATA(RDATA), .NIT_ACTIVE(NIT_ACTIVE),
  .CYCLE_NUM(CYCLE_NUM), .SLOT_NUM_B(SLOT_NUM_B), .RATE_IN(RATE_IN),
  .OFFSET_IN(OFFSET_IN), .IRQ(IRQ), .CORR_LIMIT_FLAG(CORR_LIMIT_FLAG));

// ===== sim/csr_top_test.sv
// Self-checking bench for the clock sync readout bank.
// Assumes csr_top with its checker bound; the bench drives every port.
module csr_top_test
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, nit;
  logic [5:0] cyc;
  logic [10:0] slot;
  csr_bus_req_t req;
  csr_corr_in_t ri, oi;
  wire [15:0] rdata;
  wire irq, flag;
  int fail_count = 0;
  int n_tests = 0;
  csr_top i_csr_top(.CLK(clk), .SYS_RST(rst), .BUS_REQ(req), .RDATA(rdata),
    .NIT_ACTIVE(nit), .CYCLE_NUM(cyc), .SLOT_NUM_B(slot), .RATE_IN(ri),
    .OFFSET_IN(oi), .IRQ(irq), .CORR_LIMIT_FLAG(flag));
  task close_out;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req.wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // One term strobe; limit flag is judged right after it lands
  task st(input bit r, input logic [15:0] v, input logic en, input bit f);
    @(posedge clk);
    if (r) ri <= '{1'b1, en, v};
    else oi <= '{1'b1, en, v};
    @(posedge clk) ri.vld <= 1'b0;
    oi.vld <= 1'b0;
    #1 chk({15'h0000, flag}, {15'h0000, f});
    wr(OFS_IRQ_STAT, 16'h003f);
  endtask : st
  task t_rate;
    @(posedge clk) nit <= 1'b1;
    cyc <= 6'h01;
    st(1, 16'hfff0, 1, 1);
    rd(OFS_RATE, 16'hfff0);
    wr(OFS_MAX_RATE, 16'h0010);
    st(1, 16'hfff0, 1, 0);
    st(1, 16'hffef, 1, 1);
    @(posedge clk) cyc <= 6'h02;
    st(1, 16'h0003, 1, 0);
    rd(OFS_RATE, 16'hffef);
    @(posedge clk) cyc <= 6'h03;
    st(1, 16'h0004, 0, 0);
    rd(OFS_RATE, 16'hffef);
  endtask : t_rate
  task t_offs;
    @(posedge clk) cyc <= 6'h02;
    wr(OFS_MAX_OFFSET, 16'h7fff);
    st(0, 16'h8000, 1, 1);
    rd(OFS_OFFSET, 16'h8000);
    st(0, 16'h7fff, 1, 0);
    st(0, 16'h0005, 0, 0);
    rd(OFS_OFFSET, 16'h7fff);
    @(posedge clk) nit <= 1'b0;
    st(0, 16'h0006, 1, 0);
    rd(OFS_OFFSET, 16'h7fff);
  endtask : t_offs
  task t_ro;
    @(posedge clk) slot <= 11'h5a5;
    wr(OFS_RATE, 16'h1111);
    wr(OFS_OFFSET, 16'h2222);
    wr(OFS_SLOT_B, 16'hffff);
    rd(OFS_RATE, 16'hffef);
    rd(OFS_OFFSET, 16'h7fff);
    rd(OFS_SLOT_B, 16'h05a5);
    rd(OFS_IRQ_STAT, 16'h0020);
    // Last limit hit was the offset term of the offset scenario
    rd(OFS_LIMIT_SRC, 16'h0002);
    rd(8'h40, 16'h0000);
  endtask : t_ro
  task t_irq;
    wr(OFS_IRQ_MASK, 16'h0020);
    chk({15'h0000, irq}, 16'h0001);
    wr(OFS_IRQ_MASK, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0020);
    wr(OFS_IRQ_STAT, 16'h0020);
    chk({15'h0000, irq}, 16'h0000);
  endtask : t_irq
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50us;
    fail_count++;
    close_out();
  end
  initial begin
    {rst, nit, cyc, slot, req, ri, oi} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_rate();
    t_offs();
    t_ro();
    t_irq();
    close_out();
  end
endmodule : csr_top_test
